// file: verilog/iew_pkg.sv
`default_nettype none
package iew_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint LINK_PERIOD_PS = 48000;
  localparam longint LOW_TIMEOUT_US = 35000;
  localparam int LOW_TIMEOUT_CYC =
    int'((LOW_TIMEOUT_US * 1000000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam int IDLE_TIMEOUT_CYC = 1024;
  localparam longint FAR_BIT_NS = 10000;
  localparam int FAR_QTR_CYC =
    int'((FAR_BIT_NS * 250 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  localparam int CNT_W = 20;
  localparam int FILT_WIDTH = 4;
  // ----------------------------------------------------------------
  // Byte framing and addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_PRE = 4'hF;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
  // ----------------------------------------------------------------
  // Flag positions, shared by event toggles and sticky flags
  // ----------------------------------------------------------------
  localparam int FL_BYTE = 0;
  localparam int FL_ADDR = 1;
  localparam int FL_ARB = 2;
  localparam int FL_STOP = 3;
  localparam int FL_LOW = 4;
  localparam int FL_HL = 5;
  localparam int FL_IRQ = 6;
  localparam int EV_N = 6;
  localparam logic [6:0] FLAG_RESET = 7'h00;
  // ----------------------------------------------------------------
  // Far-end commands and states
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_START = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;
  localparam logic [1:0] KIND_STOP = 2'h3;
  typedef enum logic [3:0] {
    FE_IDLE  = 4'b0001,
    FE_START = 4'b0010,
    FE_BIT   = 4'b0100,
    FE_STOP  = 4'b1000
  } iew_fe_state_t;
endpackage
`default_nettype wire

// file: verilog/iew_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iew_link_if (
  input wire logic linkClk
);
  logic sclDevOut;
  logic sclDevOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sclFarOut;
  logic sclFarOe;
  logic sdaFarOut;
  logic sdaFarOe;
  logic scl;
  logic sda;
  // Open-drain wired AND, idle lines pulled high
  assign scl = !((sclDevOe && !sclDevOut) || (sclFarOe && !sclFarOut));
  assign sda = !((sdaDevOe && !sdaDevOut) || (sdaFarOe && !sdaFarOut));
  modport dev (
    input  linkClk, scl, sda,
    output sclDevOut, sclDevOe, sdaDevOut, sdaDevOe
  );
  modport far (
    input  linkClk, scl, sda,
    output sclFarOut, sclFarOe, sdaFarOut, sdaFarOe
  );
endinterface
`default_nettype wire

// file: verilog/iew_device.sv
// Notes on behaviour
// - Events raise combined flag; stop, high/low and low-power address need enables
// - Combined flag cleared only by writing one
// - Clock-low timeout interrupts; write-one clears it
// - Stop sets flag; interrupt needs stop enable
// - High/low timeout interrupts with own enable
// - Wakeup shown as addressed flag, needs wake enable
// - Byte done on ninth falling clock edge
// - Early acknowledge moves byte done to eighth
// - Address or enabled general call sets addressed
// - Master driving high sees low: arbitration lost
// - Busy start, slave restart, unrequested stop lose
// - Arbitration lost held until written one
// - Idle timeout is status only, self clearing
// - Filter drops pulses shorter than programmed cycles
// - Low-power address match sets flag, wakes core
// - No clock stretching after wake; software restarts
// - DMA enable turns events into byte DMA requests
// - Errors still interrupt when DMA enabled
// - Software clears early acknowledge before last byte
// - Software sets not-ack, disables DMA, last byte
// - Software keeps DMA off during long addresses
// - Avoid stop mode mid-transfer without holdoff
`timescale 1ns/1ps
`default_nettype none
module iew_device
  import iew_pkg::*;
#(
  parameter int LOW_TIMEOUT  = LOW_TIMEOUT_CYC,
  parameter int IDLE_TIMEOUT = IDLE_TIMEOUT_CYC,
  parameter int FILT_W       = FILT_WIDTH
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  iew_link_if.dev         link,
  input  wire logic       busIrqEnable,
  input  wire logic       stopIrqEnable,
  input  wire logic       highLowTimeoutIrqEnable,
  input  wire logic       wakeEnable,
  input  wire logic       earlyAckEnable,
  input  wire logic       generalCallEnable,
  input  wire logic       dmaRequestEnable,
  input  wire logic       ackValueSelect,
  input  wire logic       stopHoldoffEnable,
  input  wire logic       lowPowerMode,
  input  wire logic       masterMode,
  input  wire logic       masterTxMode,
  input  wire logic       masterTxBit,
  input  wire logic [6:0] slaveAddr,
  input  wire logic [FILT_W-1:0] filterCycles,
  input  wire logic       startReq,
  input  wire logic       repStartReq,
  input  wire logic       stopReq,
  input  wire logic [6:0] flagClear,
  output logic            busIrqFlag,
  output logic            byteDoneFlag,
  output logic            addressedAsSlaveFlag,
  output logic            arbLostFlag,
  output logic            stopSeenFlag,
  output logic            clockLowTimeoutFlag,
  output logic            clkHighDataLowTimeoutFlag,
  output logic            idleHighTimeoutFlag,
  output logic            slaveDirectionBit,
  output logic            busBusy,
  output logic            irqRequest,
  output logic            dmaRequest,
  output logic            wakeRequest,
  output logic            stopModeHoldoff
);
  localparam int CFG_W = 16 + FILT_W;
  if (FILT_W < 1 || LOW_TIMEOUT < 2 || IDLE_TIMEOUT < 2 ||
      LOW_TIMEOUT >= (1 << CNT_W) - 1 || IDLE_TIMEOUT >= (1 << CNT_W) - 1)
  begin : g_bad_param
    $error("iew_device: unsupported parameter value");
  end

  function automatic logic [CNT_W-1:0] cntStep(logic [CNT_W-1:0] c,
                                                logic cond);
    if (!cond)
      cntStep = '0;
    else if (&c)
      cntStep = c;
    else
      cntStep = c + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Module clock side
  // ----------------------------------------------------------------
  logic [1:0]        rst_reg;
  logic [CFG_W-1:0]  cfg1_reg, cfg2_reg;
  logic [1:0]        pin1_reg, pin2_reg, filt_reg, prev_reg;
  logic [FILT_W-1:0] fcnt_reg [2];
  logic [CNT_W-1:0]  lowCnt_reg, hlCnt_reg, idleCnt_reg;
  logic [3:0]        bitCnt_reg;
  logic [7:0]        shift_reg;
  logic              busy_reg, firstByte_reg, slvSel_reg, slvDir_reg;
  logic              ackOe_reg, mstOe_reg, stretch_reg, clrPrev_reg;
  logic [EV_N-1:0]   evTog_reg;
  logic              linkRstn;
  logic [6:0]        cAddr;
  logic              cGce, cEarly, cAckVal, cMst, cTx, cTxBit, cLowPwr;
  logic              cStopPend, cClrTog;
  logic [FILT_W-1:0] cFilt;
  logic              sdaF, sclF, startEv, stopEv, sclRise, sclFall;
  logic              fall8, fall9, addrHit, byteEv, arbEv, lowEv, hlEv;
  logic              idleHit, ackSet, clrEv;
  logic [EV_N-1:0]   evVec;
  logic [6:0]      flag_reg;
  logic [6:0]      flag_next;
  logic [EV_N-1:0] evS1_reg, evS2_reg, evPrev_reg;
  logic [2:0]      lvS1_reg, lvS2_reg;
  logic            stopPend_reg;
  logic            byteClrTog_reg;
  logic [EV_N-1:0] evPulse;
  logic [6:0]      setVec;
  logic            arbReq;
  logic            irqSrc;
  logic            errPending;

  assign evPulse = evS2_reg ^ evPrev_reg;
  assign arbReq  = (startReq && lvS2_reg[0]) ||
                   (repStartReq && !masterMode);
  assign irqSrc  = evPulse[FL_BYTE] || evPulse[FL_ARB] || arbReq ||
                   (evPulse[FL_ADDR] && (!lowPowerMode || wakeEnable))
                   || (evPulse[FL_STOP] && stopIrqEnable)
                   || evPulse[FL_LOW]
                   || (evPulse[FL_HL] && highLowTimeoutIrqEnable);
  assign setVec  = {irqSrc, evPulse[5:3],
                    evPulse[FL_ARB] || arbReq, evPulse[1:0]};
  // Set wins over a clear arriving in the same cycle
  assign flag_next = (flag_reg & ~flagClear) | setVec;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_reg       <= FLAG_RESET;
      evS1_reg       <= '0;
      evS2_reg       <= '0;
      evPrev_reg     <= '0;
      lvS1_reg       <= '0;
      lvS2_reg       <= '0;
      stopPend_reg   <= 1'b0;
      byteClrTog_reg <= 1'b0;
    end else begin
      flag_reg       <= flag_next;
      evS1_reg       <= evTog_reg;
      evS2_reg       <= evS1_reg;
      evPrev_reg     <= evS2_reg;
      lvS1_reg       <= {slvDir_reg, idleHit, busy_reg};
      lvS2_reg       <= lvS1_reg;
      stopPend_reg   <= stopReq || (stopPend_reg && !evPulse[FL_STOP]);
      // Only a clear that really drops the flag releases the stretch
      byteClrTog_reg <= byteClrTog_reg ^ (flagClear[FL_BYTE] &&
                        flag_reg[FL_BYTE] && !setVec[FL_BYTE]);
    end
  end

  assign byteDoneFlag              = flag_reg[FL_BYTE];
  assign addressedAsSlaveFlag      = flag_reg[FL_ADDR];
  assign arbLostFlag               = flag_reg[FL_ARB];
  assign stopSeenFlag              = flag_reg[FL_STOP];
  assign clockLowTimeoutFlag       = flag_reg[FL_LOW];
  assign clkHighDataLowTimeoutFlag = flag_reg[FL_HL];
  assign busIrqFlag                = flag_reg[FL_IRQ];
  assign busBusy                   = lvS2_reg[0];
  assign idleHighTimeoutFlag       = lvS2_reg[1];
  assign slaveDirectionBit         = lvS2_reg[2];
  // Errors bypass DMA steering so they always reach the processor
  assign errPending = flag_reg[FL_ARB] || flag_reg[FL_LOW];
  assign irqRequest = busIrqFlag && busIrqEnable &&
                      (!dmaRequestEnable || errPending);
  assign dmaRequest = busIrqEnable && dmaRequestEnable &&
                      byteDoneFlag;
  assign wakeRequest = lowPowerMode && busIrqEnable && wakeEnable &&
                       addressedAsSlaveFlag;
  assign stopModeHoldoff = stopHoldoffEnable && busBusy;

  // ----------------------------------------------------------------
  // Link clock side
  // ----------------------------------------------------------------
  assign linkRstn = rst_reg[1];
  assign {cAddr, cGce, cEarly, cAckVal, cMst, cTx, cTxBit, cLowPwr,
          cStopPend, cClrTog, cFilt} = cfg2_reg;
  assign sdaF    = filt_reg[0];
  assign sclF    = filt_reg[1];
  assign sclRise = sclF && !prev_reg[1];
  assign sclFall = !sclF && prev_reg[1];
  assign startEv = sclF && prev_reg[1] && !sdaF && prev_reg[0];
  assign stopEv  = sclF && prev_reg[1] && sdaF && !prev_reg[0];
  assign fall8   = sclFall && bitCnt_reg == BIT_LAST_DATA;
  assign fall9   = sclFall && bitCnt_reg == BIT_ACK;
  assign byteEv  = cEarly ? fall8 : fall9;
  assign addrHit = fall8 && firstByte_reg &&
                   (shift_reg[7:1] == cAddr ||
                    (cGce && shift_reg[7:1] == GENERAL_CALL_ADDR));
  assign arbEv   = (cMst && sclRise && !sdaF &&
                    ((cTx && cTxBit && bitCnt_reg < BIT_ACK) ||
                     (!cTx && cAckVal && bitCnt_reg == BIT_ACK))) ||
                   (cMst && stopEv && !cStopPend);
  assign lowEv   = !sclF && lowCnt_reg == CNT_W'(LOW_TIMEOUT - 1);
  assign hlEv    = sclF && !sdaF &&
                   hlCnt_reg == CNT_W'(IDLE_TIMEOUT - 1);
  // Level only, never routed to an interrupt
  assign idleHit = idleCnt_reg >= CNT_W'(IDLE_TIMEOUT);
  assign ackSet  = (addrHit || (slvSel_reg && !slvDir_reg &&
                    !firstByte_reg) || (cMst && !cTx)) && !cAckVal;
  assign clrEv   = cClrTog ^ clrPrev_reg;
  assign evVec   = {hlEv, lowEv, stopEv, arbEv, addrHit, byteEv};

  assign link.sclDevOut = 1'b0;
  assign link.sdaDevOut = 1'b0;
  assign link.sclDevOe  = stretch_reg;
  assign link.sdaDevOe  = ackOe_reg || mstOe_reg;

  always_ff @(posedge link.linkClk) begin
    rst_reg  <= {rst_reg[0], resetn};
    cfg1_reg <= {slaveAddr, generalCallEnable, earlyAckEnable,
                 ackValueSelect, masterMode, masterTxMode, masterTxBit,
                 lowPowerMode, stopPend_reg, byteClrTog_reg, filterCycles};
    cfg2_reg <= cfg1_reg;
    pin1_reg <= {link.scl, link.sda};
    pin2_reg <= pin1_reg;
  end

  // Glitch filter: a level must persist cFilt cycles to pass
  always_ff @(posedge link.linkClk) begin
    if (!linkRstn) begin
      filt_reg <= 2'b11;
      prev_reg <= 2'b11;
      fcnt_reg <= '{default: '0};
    end else begin
      prev_reg <= filt_reg;
      for (int i = 0; i < 2; i++) begin
        if (pin2_reg[i] == filt_reg[i]) begin
          fcnt_reg[i] <= '0;
        end else if ({1'b0, fcnt_reg[i]} + 1'b1 >= {1'b0, cFilt}) begin
          filt_reg[i] <= pin2_reg[i];
          fcnt_reg[i] <= '0;
        end else begin
          fcnt_reg[i] <= fcnt_reg[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge link.linkClk) begin
    if (!linkRstn) begin
      lowCnt_reg    <= '0;
      hlCnt_reg     <= '0;
      idleCnt_reg   <= '0;
      bitCnt_reg    <= BIT_PRE;
      shift_reg     <= 8'h00;
      busy_reg      <= 1'b0;
      firstByte_reg <= 1'b0;
      slvSel_reg    <= 1'b0;
      slvDir_reg    <= 1'b0;
      ackOe_reg     <= 1'b0;
      mstOe_reg     <= 1'b0;
      stretch_reg   <= 1'b0;
      clrPrev_reg   <= 1'b0;
      evTog_reg     <= '0;
    end else begin
      lowCnt_reg  <= cntStep(lowCnt_reg, !sclF);
      hlCnt_reg   <= cntStep(hlCnt_reg, sclF && !sdaF);
      idleCnt_reg <= cntStep(idleCnt_reg, sclF && sdaF);
      clrPrev_reg <= cClrTog;
      evTog_reg   <= evTog_reg ^ evVec;
      busy_reg    <= startEv || (busy_reg && !stopEv);
      mstOe_reg   <= cMst && cTx && !cTxBit && bitCnt_reg < BIT_ACK;
      if (startEv || stopEv) begin
        bitCnt_reg    <= BIT_PRE;
        firstByte_reg <= startEv;
        slvSel_reg    <= 1'b0;
        ackOe_reg     <= 1'b0;
      end else if (sclFall) begin
        bitCnt_reg <= (bitCnt_reg == BIT_PRE || bitCnt_reg == BIT_ACK) ?
                      4'h0 : bitCnt_reg + 4'h1;
        if (fall9) begin
          firstByte_reg <= 1'b0;
          ackOe_reg     <= 1'b0;
        end else if (fall8) begin
          ackOe_reg <= ackSet;
        end
        if (addrHit) begin
          slvSel_reg <= 1'b1;
          slvDir_reg <= shift_reg[0];
        end
      end else if (sclRise && bitCnt_reg < BIT_ACK) begin
        shift_reg <= {shift_reg[6:0], sdaF};
      end
      // Hold clock low until the byte flag is cleared; never after a
      // low-power wake, the core restarts the module instead
      if (startEv || stopEv || clrEv || cLowPwr)
        stretch_reg <= 1'b0;
      else if (byteEv)
        stretch_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verilog/iew_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module iew_far_end
  import iew_pkg::*;
#(
  parameter int QTR = FAR_QTR_CYC
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  iew_link_if.far         link,
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire logic [1:0] cmdKind,
  input  wire logic [7:0] cmdByte,
  output logic            respValid,
  output logic [7:0]      respByte,
  output logic            respAckSeen
);
  if (QTR < 2 || QTR > 65535) begin : g_bad_param
    $error("iew_far_end: unsupported QTR");
  end

  function automatic logic bitOut(logic [1:0] k, logic [7:0] b,
                                  logic [3:0] i);
    if (i < BIT_ACK)
      bitOut = (k == KIND_WRITE) ? b[3'(BIT_LAST_DATA - i)] : 1'b1;
    else
      bitOut = (k == KIND_READ) ? b[0] : 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Command side, module clock
  // ----------------------------------------------------------------
  iew_fe_state_t state_reg;
  logic [1:0]    rst_reg, pin1_reg, pin2_reg;
  logic          rS1_reg, rS2_reg, rPrev_reg, doneTog_reg;
  logic          sclOe_reg, sdaOe_reg, ackSeen_reg;
  logic [15:0]   qCnt_reg;
  logic [1:0]    phase_reg;
  logic [3:0]    bitIdx_reg;
  logic [7:0]    rx_reg;
  logic          tick, go, sclHigh, sdaIn;
  logic       busy_reg, reqTog_reg, dS1_reg, dS2_reg, dPrev_reg;
  logic [1:0] kind_reg;
  logic [7:0] byte_reg;
  logic       doneEdge;

  assign cmdReady = !busy_reg;
  assign doneEdge = dS2_reg ^ dPrev_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_reg    <= 1'b0;
      reqTog_reg  <= 1'b0;
      dS1_reg     <= 1'b0;
      dS2_reg     <= 1'b0;
      dPrev_reg   <= 1'b0;
      kind_reg    <= KIND_START;
      byte_reg    <= 8'h00;
      respValid   <= 1'b0;
      respByte    <= 8'h00;
      respAckSeen <= 1'b0;
    end else begin
      dS1_reg   <= doneTog_reg;
      dS2_reg   <= dS1_reg;
      dPrev_reg <= dS2_reg;
      respValid <= doneEdge;
      if (cmdValid && !busy_reg) begin
        busy_reg   <= 1'b1;
        reqTog_reg <= !reqTog_reg;
        kind_reg   <= cmdKind;
        byte_reg   <= cmdByte;
      end else if (doneEdge) begin
        busy_reg    <= 1'b0;
        respByte    <= rx_reg;
        respAckSeen <= ackSeen_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus side, link clock
  // ----------------------------------------------------------------
  assign sclHigh = pin2_reg[1];
  assign sdaIn   = pin2_reg[0];
  assign go      = rS2_reg ^ rPrev_reg;
  // After release, a stretched clock pauses the timer while scl is low
  assign tick    = qCnt_reg == 16'(QTR - 1) &&
                   !(phase_reg == 2'h2 && !sclHigh && state_reg != FE_START);
  assign link.sclFarOut = 1'b0;
  assign link.sdaFarOut = 1'b0;
  assign link.sclFarOe  = sclOe_reg;
  assign link.sdaFarOe  = sdaOe_reg;

  always_ff @(posedge link.linkClk) begin
    rst_reg  <= {rst_reg[0], resetn};
    pin1_reg <= {link.scl, link.sda};
    pin2_reg <= pin1_reg;
    rS1_reg  <= reqTog_reg;
    rS2_reg  <= rS1_reg;
  end

  always_ff @(posedge link.linkClk) begin
    if (!rst_reg[1]) begin
      state_reg   <= FE_IDLE;
      rPrev_reg   <= 1'b0;
      doneTog_reg <= 1'b0;
      sclOe_reg   <= 1'b0;
      sdaOe_reg   <= 1'b0;
      ackSeen_reg <= 1'b0;
      qCnt_reg    <= 16'h0000;
      phase_reg   <= 2'h0;
      bitIdx_reg  <= 4'h0;
      rx_reg      <= 8'h00;
    end else begin
      rPrev_reg <= rS2_reg;
      qCnt_reg  <= (state_reg == FE_IDLE || tick) ? 16'h0000 :
                   (qCnt_reg == 16'(QTR - 1) ? qCnt_reg : qCnt_reg + 16'h1);
      if (state_reg != FE_IDLE && tick)
        phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        FE_IDLE: begin
          phase_reg  <= 2'h0;
          bitIdx_reg <= 4'h0;
          if (go) begin
            case (kind_reg)
              KIND_START: state_reg <= FE_START;
              KIND_STOP:  state_reg <= FE_STOP;
              default:    state_reg <= FE_BIT;
            endcase
          end
        end
        FE_START: begin
          if (tick) begin
            case (phase_reg)
              2'h0: sdaOe_reg <= 1'b1;
              2'h1: sclOe_reg <= 1'b1;
              default: begin
                state_reg   <= FE_IDLE;
                doneTog_reg <= !doneTog_reg;
              end
            endcase
          end
        end
        FE_BIT: begin
          if (tick) begin
            case (phase_reg)
              2'h0: sdaOe_reg <= !bitOut(kind_reg, byte_reg, bitIdx_reg);
              2'h1: sclOe_reg <= 1'b0;
              2'h2: begin
                if (bitIdx_reg < BIT_ACK)
                  rx_reg <= {rx_reg[6:0], sdaIn};
                else
                  ackSeen_reg <= !sdaIn;
              end
              default: begin
                sclOe_reg  <= 1'b1;
                bitIdx_reg <= bitIdx_reg + 4'h1;
                if (bitIdx_reg == BIT_ACK) begin
                  sdaOe_reg   <= 1'b0;
                  state_reg   <= FE_IDLE;
                  doneTog_reg <= !doneTog_reg;
                end
              end
            endcase
          end
        end
        FE_STOP: begin
          if (tick) begin
            case (phase_reg)
              2'h0: sdaOe_reg <= 1'b1;
              2'h1: sclOe_reg <= 1'b0;
              default: begin
                sdaOe_reg   <= 1'b0;
                state_reg   <= FE_IDLE;
                doneTog_reg <= !doneTog_reg;
              end
            endcase
          end
        end
        default: state_reg <= FE_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/iew_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module iew_asserts (
  input wire logic
    mclk,
    resetn,
    scl,
    busIrqEnable,
    dmaRequestEnable,
    busIrqFlag,
    byteDoneFlag,
    arbLostFlag,
    clockLowTimeoutFlag,
    idleHighTimeoutFlag,
    irqRequest,
    dmaRequest,
  input wire logic [6:0]
    flagClear
);
  // ------------------------------------
  // Flag and request relations
  // ------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence irqHeld;
    busIrqFlag && !flagClear[6];
  endsequence
  sequence errPending;
    busIrqFlag && busIrqEnable && (arbLostFlag || clockLowTimeoutFlag);
  endsequence
  // Enables feed irqRequest with no sync, yet the check waits 4 settled cycles
  sequence plainMode;
    (busIrqEnable && !dmaRequestEnable)[*4] ##0 busIrqFlag;
  endsequence
  a_irq_gated:
    assert property (irqRequest |-> busIrqFlag && busIrqEnable)
    else $error("irq request without flag and enable");
  a_irq_plain:
    assert property (plainMode |-> irqRequest)
    else $error("irq request missing");
  a_err_irq:
    assert property (errPending |-> irqRequest)
    else $error("error event without irq request");
  a_dma_byte:
    assert property (dmaRequest |-> byteDoneFlag && dmaRequestEnable)
    else $error("dma request without byte done");
  a_irq_sticky:
    assert property (irqHeld |=> busIrqFlag)
    else $error("combined flag fell without clear");
  a_arb_sticky:
    assert property (arbLostFlag && !flagClear[2] |=> arbLostFlag)
    else $error("arbitration flag fell without clear");
  a_low_clear:
    assert property ($fell(clockLowTimeoutFlag) |-> $past(flagClear[4]))
    else $error("low timeout flag fell without clear");
  a_idle_falls:
    assert property ($fell(scl) |-> ##[1:40] !idleHighTimeoutFlag)
    else $error("idle flag stuck while bus active");
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import iew_pkg::*;
;
  typedef struct packed {
    logic [7:0] b;
    logic       g, d, e;
  } iew_row_t;
  logic mclk = 0, linkClk = 0, resetn = 0, busIrqEnable = 1;
  logic stopIrqEnable = 0, highLowTimeoutIrqEnable = 0, wakeEnable = 0;
  logic earlyAckEnable = 0, generalCallEnable = 0, dmaRequestEnable = 0;
  logic ackValueSelect = 0, stopHoldoffEnable = 0, lowPowerMode = 0;
  logic masterMode = 0, masterTxMode = 0, masterTxBit = 1, startReq = 0;
  logic repStartReq = 0, stopReq = 0, cmdValid = 0;
  logic [6:0] slaveAddr = 7'h52, flagClear = 7'h00, clrReq = 7'h00;
  logic [3:0] filterCycles = 4'h1;
  logic [1:0] cmdKind = 2'h0;
  logic [7:0] cmdByte = 8'h00, respByte;
  logic busIrqFlag, byteDoneFlag, addressedAsSlaveFlag, arbLostFlag;
  logic stopSeenFlag, clockLowTimeoutFlag, clkHighDataLowTimeoutFlag;
  logic idleHighTimeoutFlag, slaveDirectionBit, busBusy, irqRequest;
  logic dmaRequest, wakeRequest, stopModeHoldoff, cmdReady, respValid;
  logic respAckSeen;
  int n_fail = 0, n_compared = 0;
  iew_row_t rows [4] = '{{8'hA4, 3'h1}, {8'h30, 3'h0}, {8'h00, 3'h7},
                         {8'h00, 3'h0}};
  always #10 mclk = ~mclk;
  always #24 linkClk = ~linkClk;
  // Byte done cleared at once, else the device stretches the clock
  always @(posedge mclk) flagClear <= clrReq | {6'h00, byteDoneFlag};
  iew_link_if i_iew_link_if (.linkClk);
  iew_device #(.LOW_TIMEOUT(200), .IDLE_TIMEOUT(40)) i_iew_device (
    .mclk, .resetn, .link(i_iew_link_if), .busIrqEnable, .stopIrqEnable,
    .highLowTimeoutIrqEnable, .wakeEnable, .earlyAckEnable,
    .generalCallEnable, .dmaRequestEnable, .ackValueSelect,
    .stopHoldoffEnable, .lowPowerMode, .masterMode, .masterTxMode,
    .masterTxBit, .slaveAddr, .filterCycles, .startReq, .repStartReq,
    .stopReq, .flagClear, .busIrqFlag, .byteDoneFlag, .addressedAsSlaveFlag,
    .arbLostFlag, .stopSeenFlag, .clockLowTimeoutFlag,
    .clkHighDataLowTimeoutFlag, .idleHighTimeoutFlag, .slaveDirectionBit,
    .busBusy, .irqRequest, .dmaRequest, .wakeRequest, .stopModeHoldoff);
  iew_far_end #(.QTR(4)) i_iew_far_end (.mclk, .resetn,
    .link(i_iew_link_if), .cmdValid, .cmdReady, .cmdKind, .cmdByte,
    .respValid, .respByte, .respAckSeen);
  iew_asserts i_iew_asserts (.mclk, .resetn, .scl(i_iew_link_if.scl),
    .busIrqEnable, .dmaRequestEnable, .busIrqFlag, .byteDoneFlag,
    .arbLostFlag, .clockLowTimeoutFlag, .idleHighTimeoutFlag,
    .irqRequest, .dmaRequest, .flagClear);
  // ------------------------------------
  // Shared tasks
  // ------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cmd(input logic [1:0] k, input logic [7:0] b);
    int t;
    cmdKind <= k;
    cmdByte <= b;
    cmdValid <= 1;
    do @(posedge mclk); while (!cmdReady);
    cmdValid <= 0;
    t = 0;
    do begin @(posedge mclk); t++; end while (!respValid && t < 20000);
    if (t >= 20000) chk(1'h0, 1'h1);
  endtask
  task clear;
    clrReq <= 7'h7F;
    @(posedge mclk);
    clrReq <= 7'h00;
    repeat (6) @(posedge mclk);
  endtask
  task final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    final_report;
  end
  // ------------------------------------
  // Scenarios
  // ------------------------------------
  initial begin
    // Six cycles still span two link clock edges
    repeat (6) @(posedge mclk);
    resetn <= 1;
    repeat (200) @(posedge mclk);
    chk(idleHighTimeoutFlag, 1);
    chk(busIrqFlag, 0);
    chk(i_iew_link_if.scl & i_iew_link_if.sda, 1);
    foreach (rows[i]) begin
      generalCallEnable <= rows[i].g;
      dmaRequestEnable <= rows[i].d;
      repeat (10) @(posedge mclk);
      cmd(KIND_START, 8'h00);
      cmd(KIND_WRITE, rows[i].b);
      repeat (8) @(posedge mclk);
      chk(addressedAsSlaveFlag, rows[i].e);
      chk(respAckSeen, rows[i].e);
      if (rows[i].e) chk(irqRequest, !rows[i].d);
      cmd(KIND_STOP, 8'h00);
      repeat (20) @(posedge mclk);
      chk(stopSeenFlag, 1);
      clear;
    end
    stopHoldoffEnable <= 1;
    dmaRequestEnable <= 1;
    cmd(KIND_START, 8'h00);
    repeat (10) @(posedge mclk);
    startReq <= 1;
    @(posedge mclk);
    startReq <= 0;
    repeat (20) @(posedge mclk);
    chk(arbLostFlag, 1);
    chk(irqRequest, 1);
    chk(stopModeHoldoff, 1);
    repeat (700) @(posedge mclk);
    chk(arbLostFlag, 1);
    chk(clockLowTimeoutFlag, 1);
    cmd(KIND_STOP, 8'h00);
    repeat (10) @(posedge mclk);
    clear;
    chk(arbLostFlag | clockLowTimeoutFlag, 0);
    chk(busIrqFlag, 0);
    repStartReq <= 1;
    @(posedge mclk);
    repStartReq <= 0;
    repeat (20) @(posedge mclk);
    chk(arbLostFlag, 1);
    clear;
    masterMode <= 1;
    masterTxMode <= 1;
    dmaRequestEnable <= 0;
    earlyAckEnable <= 0;
    repeat (10) @(posedge mclk);
    cmd(KIND_START, 8'h00);
    cmd(KIND_READ, 8'h01);
    chk(respByte, 8'hFF);
    chk(arbLostFlag, 0);
    cmd(KIND_WRITE, 8'h00);
    repeat (20) @(posedge mclk);
    chk(arbLostFlag, 1);
    clear;
    cmd(KIND_STOP, 8'h00);
    repeat (20) @(posedge mclk);
    chk(arbLostFlag, 1);
    final_report;
  end
endmodule
`default_nettype wire
